//--- verilog/fwp_pkg.sv
// Package: register map, field layout and reset values of the flash write-protect block
package fwp_pkg;
  localparam logic [11:0] FWP_CTL_OFFSET   = 12'h000;
  localparam logic [11:0] FWP_KEY_OFFSET   = 12'h004;
  localparam logic [11:0] FWP_STAT_OFFSET  = 12'h008;
  localparam int          FWP_UNLOCK_BIT   = 31;
  localparam int          FWP_BOUND_W      = 24;
  localparam int          FWP_PAGE_LSB     = 14;
  localparam logic [31:0] FWP_KEY_FIRST    = 32'haa996655;
  localparam logic [31:0] FWP_KEY_SECOND   = 32'h556699aa;
  localparam logic        FWP_UNLOCK_RST   = 1'b1;
  localparam logic [23:0] FWP_BOUND_RST    = 24'h000000;
  localparam logic [31:0] FWP_UNMAPPED_VAL = 32'h00000000;

  typedef enum logic [1:0] {FWP_KEY_IDLE, FWP_KEY_HALF, FWP_KEY_OPEN} fwp_key_e;

  typedef struct packed {
    logic        valid;
    logic        erase;
    logic [23:0] addr;
  } fwp_op_s;
endpackage : fwp_pkg

//--- verilog/fwp_page_cmp.sv
// Page comparator: is an operation's page at or below a nonzero boundary page
`timescale 1ns/100ps
module fwp_page_cmp
  import fwp_pkg::*;
(
  input  wire logic [23:0] boundary,
  input  wire logic [23:0] op_addr,
  output logic             protected_hit
);
  always_comb begin
    if (boundary == FWP_BOUND_RST) begin
      protected_hit = 1'b0;
    end else begin
      // Whole pages: boundary page and every page under it
      protected_hit = op_addr[23:FWP_PAGE_LSB] <= boundary[23:FWP_PAGE_LSB];
    end
  end
endmodule : fwp_page_cmp

//--- verilog/fwp_top.sv
// Flash write-protect register, key gate and operation filter behind an APB slave
// Notes on behaviour
// - While unlock bit 31 is one, software may modify the register.
// - Once unlock bit is zero, all writes to the register are ignored.
// - Software can only clear unlock; any reset sets it, resets to one.
// - Boundary field is the low address part inside program flash.
// - Boundary zero means no write protection anywhere.
// - Boundary page and all lower pages are protected.
// - Register writes need a preceding key sequence, else discarded.
// - Bits 30 to 24 read zero, writes ignored.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module fwp_top
  import fwp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire fwp_op_s     op_req,
  output fwp_op_s          op_grant,
  output logic             op_blocked
);
  logic        protect_reg_unlock;
  logic [23:0] protect_boundary_addr;
  fwp_key_e    key_state;
  logic [31:0] prdata_q;
  logic        blocked_q;
  fwp_op_s     grant_q;
  logic        next_protect_reg_unlock;
  logic [23:0] next_protect_boundary_addr;
  fwp_key_e    next_key_state;
  logic [31:0] next_prdata;
  logic        next_blocked;
  fwp_op_s     next_grant;
  logic        hit;
  logic        wr_acc;
  logic        rd_acc;
  logic        ctl_sel;
  logic        key_sel;
  logic        stat_sel;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = prdata_q;
  assign op_grant   = grant_q;
  assign op_blocked = blocked_q;
  // Writes act on the single access phase edge since pready is always high; reads act on the setup phase edge
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  fwp_page_cmp u_cmp (
    .boundary      (protect_boundary_addr),
    .op_addr       (op_req.addr),
    .protected_hit (hit)
  );

  // Address decode shared by the write and read paths; other offsets select nothing
  always_comb begin
    ctl_sel  = 1'b0;
    key_sel  = 1'b0;
    stat_sel = 1'b0;
    if (paddr == FWP_CTL_OFFSET) begin
      ctl_sel = 1'b1;
    end else if (paddr == FWP_KEY_OFFSET) begin
      key_sel = 1'b1;
    end else if (paddr == FWP_STAT_OFFSET) begin
      stat_sel = 1'b1;
    end
  end

  always_comb begin
    next_protect_reg_unlock    = protect_reg_unlock;
    next_protect_boundary_addr = protect_boundary_addr;
    next_key_state             = key_state;
    // Key writes only move the key tracker, never the register itself
    if (wr_acc && key_sel) begin
      if (pwdata == FWP_KEY_FIRST) begin
        next_key_state = FWP_KEY_HALF;
      end else if (pwdata == FWP_KEY_SECOND && key_state == FWP_KEY_HALF) begin
        next_key_state = FWP_KEY_OPEN;
      end else begin
        next_key_state = FWP_KEY_IDLE;
      end
    end else if (wr_acc && ctl_sel) begin
      // Key is spent by any control write, accepted or not
      next_key_state = FWP_KEY_IDLE;
      if (key_state == FWP_KEY_OPEN && protect_reg_unlock) begin
        next_protect_boundary_addr = pwdata[FWP_BOUND_W-1:0];
        // Only a clear can stick; a one leaves it alone
        next_protect_reg_unlock = protect_reg_unlock & pwdata[FWP_UNLOCK_BIT];
      end
    end else if (wr_acc) begin
      next_key_state = FWP_KEY_IDLE;
    end
  end

  always_comb begin
    next_prdata = prdata_q;
    if (rd_acc) begin
      if (ctl_sel) begin
        next_prdata = {protect_reg_unlock, 7'h00, protect_boundary_addr};
      end else if (stat_sel) begin
        next_prdata = {30'h00000000, key_state == FWP_KEY_OPEN, key_state == FWP_KEY_HALF};
      end else begin
        next_prdata = FWP_UNMAPPED_VAL;
      end
    end
  end

  always_comb begin
    // Blocked requests keep their fields; only valid is dropped
    next_grant   = op_req;
    next_blocked = 1'b0;
    if (op_req.valid && hit) begin
      next_grant.valid = 1'b0;
      next_blocked     = 1'b1;
    end
  end

  // Register group: unlock, boundary and key progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_reg_unlock    <= FWP_UNLOCK_RST;
      protect_boundary_addr <= FWP_BOUND_RST;
      key_state             <= FWP_KEY_IDLE;
    end else begin
      protect_reg_unlock    <= next_protect_reg_unlock;
      protect_boundary_addr <= next_protect_boundary_addr;
      key_state             <= next_key_state;
    end
  end

  // Read data group; loaded in the setup phase so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= next_prdata;
    end
  end

  // Operation filter group; one cycle of latency keeps the compare off the output path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_q   <= '0;
      blocked_q <= 1'b0;
    end else begin
      grant_q   <= next_grant;
      blocked_q <= next_blocked;
    end
  end

  // Register protection checks
  AST_LOCK_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
    !protect_reg_unlock |=> $stable(protect_boundary_addr) && !protect_reg_unlock)
    else $error("Locked register changed");

  AST_UNLOCK_NEVER_SET: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(protect_reg_unlock) |-> 1'b0)
    else $error("Unlock bit set by software");

  AST_UNLOCK_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && ctl_sel && key_state == FWP_KEY_OPEN && protect_reg_unlock
      && !pwdata[FWP_UNLOCK_BIT]) |=> !protect_reg_unlock)
    else $error("Unlock clear lost");

  AST_UNLOCK_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && ctl_sel && key_state == FWP_KEY_OPEN && protect_reg_unlock
      && pwdata[FWP_UNLOCK_BIT]) |=> protect_reg_unlock)
    else $error("Unlock bit dropped by an open write");

  AST_NO_KEY_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && ctl_sel && key_state != FWP_KEY_OPEN)
      |=> $stable(protect_boundary_addr) && $stable(protect_reg_unlock))
    else $error("Write accepted without key");

  AST_KEYED_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && ctl_sel && key_state == FWP_KEY_OPEN && protect_reg_unlock)
      |=> protect_boundary_addr == $past(pwdata[FWP_BOUND_W-1:0]))
    else $error("Keyed write lost");

  // Key sequence checks
  AST_KEY_SPENT: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && ctl_sel) |=> key_state == FWP_KEY_IDLE)
    else $error("Key survived a control write");

  AST_KEY_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(key_state) && key_state == FWP_KEY_OPEN
      |-> $past(key_state) == FWP_KEY_HALF && $past(pwdata) == FWP_KEY_SECOND)
    else $error("Key opened out of order");

  // Read path checks
  AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    $past(rd_acc) && $past(ctl_sel) |-> prdata[30:24] == 7'h00)
    else $error("Reserved bits not zero");

  AST_READ_LAYOUT: assert property (@(posedge pclk) disable iff (!presetn)
    $past(rd_acc) && $past(ctl_sel)
      |-> prdata == {$past(protect_reg_unlock), 7'h00, $past(protect_boundary_addr)})
    else $error("Control read layout wrong");

  // Operation filter checks
  AST_ZERO_NO_PROT: assert property (@(posedge pclk) disable iff (!presetn)
    op_req.valid && protect_boundary_addr == FWP_BOUND_RST
      |=> op_grant.valid && !op_blocked)
    else $error("Operation blocked with zero boundary");

  AST_BLOCK_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    op_req.valid && protect_boundary_addr != FWP_BOUND_RST
      && op_req.addr[23:FWP_PAGE_LSB] <= protect_boundary_addr[23:FWP_PAGE_LSB]
      |=> op_blocked && !op_grant.valid)
    else $error("Protected page passed");

  AST_PASS_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    op_req.valid && op_req.addr[23:FWP_PAGE_LSB] > protect_boundary_addr[23:FWP_PAGE_LSB]
      |=> op_grant.valid && op_grant.addr == $past(op_req.addr))
    else $error("Unprotected page blocked");

  AST_BLOCKED_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !op_req.valid |=> !op_blocked && !op_grant.valid)
    else $error("Filter output without a request");

  AST_GRANT_COPY: assert property (@(posedge pclk) disable iff (!presetn)
    op_req.valid |=> op_grant.erase == $past(op_req.erase)
      && op_grant.addr == $past(op_req.addr))
    else $error("Granted operation altered");
endmodule : fwp_top

//--- verification/fwp_testbench.sv
// Self-checking testbench for the flash write-protect block
`timescale 1ns/100ps
module testbench
  import fwp_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic        pready, pslverr, op_blocked;
  fwp_op_s     op_req = '0, op_grant;
  int          n_mismatch = 0, checks = 0, cyc = 0;
  // Bit 25 expected block, bit 24 erase, 23:0 address; boundary sits in page 3
  localparam logic [25:0] ROWS [6] = '{26'h3000000, 26'h200ffff, 26'h1010000,
                                       26'h0ffffff, 26'h3008000, 26'h0014000};

  fwp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_req(op_req), .op_grant(op_grant), .op_blocked(op_blocked));

  initial begin
    forever #5 pclk = ~pclk;
  end

  task give_verdict;
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Request held until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task key_wr(input logic [31:0] d);
    apb(1'b1, FWP_KEY_OFFSET, FWP_KEY_FIRST);
    apb(1'b1, FWP_KEY_OFFSET, FWP_KEY_SECOND);
    apb(1'b1, FWP_CTL_OFFSET, d);
  endtask : key_wr

  task op(input logic [25:0] row);
    @(posedge pclk);
    op_req <= '{valid: 1'b1, erase: row[24], addr: row[23:0]};
    @(posedge pclk);
    op_req.valid <= 1'b0;
    #1;
    chk("op_blocked", {31'h0, op_blocked}, {31'h0, row[25]});
    chk("op_grant", {6'h0, op_grant}, {6'h0, ~row[25], row[24], row[23:0]});
  endtask : op

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FWP_CTL_OFFSET, 32'h0);
    chk("ctl reset", rd, 32'h80000000);
    op(26'h0000000);
    apb(1'b1, FWP_CTL_OFFSET, 32'h8000c000);
    chk("pslverr", {31'h0, pslverr}, 32'h00000000);
    apb(1'b0, FWP_CTL_OFFSET, 32'h0);
    chk("ctl no key", rd, 32'h80000000);
    // Half key shows, and a stray write in between throws it away
    apb(1'b1, FWP_KEY_OFFSET, FWP_KEY_FIRST);
    apb(1'b0, FWP_STAT_OFFSET, 32'h0);
    chk("stat half", rd, 32'h00000001);
    apb(1'b1, 12'h00c, 32'h0);
    apb(1'b0, FWP_STAT_OFFSET, 32'h0);
    chk("stat broken", rd, 32'h00000000);
    // Full key survives a read; bits 30:24 set on purpose
    apb(1'b1, FWP_KEY_OFFSET, FWP_KEY_FIRST);
    apb(1'b1, FWP_KEY_OFFSET, FWP_KEY_SECOND);
    apb(1'b0, FWP_STAT_OFFSET, 32'h0);
    chk("stat open", rd, 32'h00000002);
    apb(1'b1, FWP_CTL_OFFSET, 32'hff00c000);
    apb(1'b0, FWP_CTL_OFFSET, 32'h0);
    chk("ctl keyed", rd, 32'h8000c000);
    for (int i = 0; i < 6; i++) op(ROWS[i]);
    apb(1'b1, FWP_CTL_OFFSET, 32'h8000ffff);
    apb(1'b0, FWP_CTL_OFFSET, 32'h0);
    chk("ctl key spent", rd, 32'h8000c000);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped", rd, 32'h00000000);
    key_wr(32'h0000c000);
    key_wr(32'h80000000); // Set attempt after clearing must fail
    apb(1'b0, FWP_CTL_OFFSET, 32'h0);
    chk("ctl locked", rd, 32'h0000c000);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FWP_CTL_OFFSET, 32'h0);
    chk("ctl rereset", rd, 32'h80000000);
    op(26'h0000000);
    give_verdict();
  end
endmodule : testbench
